// ===== dv/obd_info_model.sv
// Information block model serving the four option words
`timescale 1ns/1ps
module obd_info_model (
	input wire pclk,
	input wire presetn,
	input wire info_req,
	input wire [1:0] info_index,
	input wire [127:0] words,
	input wire [1:0] delay,
	output reg [31:0] info_rdata,
	output reg info_valid
);
reg [1:0] cnt;
// Data is not held after a word is taken: toggle it so a late sample shows
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		info_valid <= 1'b0;
		info_rdata <= 32'h0;
		cnt <= 2'h0;
	end else if (info_valid || !info_req) begin
		info_valid <= 1'b0;
		info_rdata <= ~info_rdata;
		cnt <= 2'h0;
	end else if (cnt >= delay) begin
		info_valid <= 1'b1;
		info_rdata <= words[info_index*32 +: 32];
	end else begin
		cnt <= cnt + 2'h1;
		info_rdata <= ~info_rdata;
	end
end
endmodule // obd_info_model

// ===== dv/obd_option_byte_decoder_properties.sv
// Port assertions of the option byte decoder
`timescale 1ns/1ps
module obd_properties #(parameter ADDR_WIDTH = 8) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_WIDTH-1:0] paddr,
	input wire [31:0] prdata,
	input wire info_req,
	input wire [1:0] info_index,
	input wire info_valid,
	input wire standby_entry,
	input wire stop_entry,
	input wire loading,
	input wire watchdog_software_select,
	input wire hardware_watchdog_start,
	input wire standby_reset_inhibit,
	input wire stop_reset_inhibit,
	input wire low_power_reset,
	input wire read_protect_active
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
sequence s_osr_rd;
	psel && penable && !pwrite && paddr == '0 && !loading;
endsequence
sequence s_last_take;
	info_req && info_valid && info_index == 2'd3;
endsequence
property p_osr_flags;
	s_osr_rd |-> prdata[4:1] == {standby_reset_inhibit, stop_reset_inhibit,
		watchdog_software_select, read_protect_active};
endproperty
property p_unused;
	s_osr_rd |-> prdata[9:5] == 5'h1f;
endproperty
property p_wdg;
	hardware_watchdog_start != watchdog_software_select;
endproperty
property p_stop;
	stop_entry && !stop_reset_inhibit |=> low_power_reset;
endproperty
property p_stdby;
	standby_entry && !standby_reset_inhibit |=> low_power_reset;
endproperty
property p_quiet;
	!(stop_entry && !stop_reset_inhibit) && !(standby_entry && !standby_reset_inhibit)
		|=> !low_power_reset;
endproperty
property p_hold;
	info_req && !info_valid |=> info_req && $stable(info_index);
endproperty
property p_last;
	s_last_take |=> !info_req ##1 !info_req;
endproperty
property p_load;
	loading |-> ##[0:60] !loading;
endproperty
a_osr_flags: assert property (p_osr_flags) else $error("flag outputs differ from status");
a_unused: assert property (p_unused) else $error("unused user bits wrong");
a_wdg: assert property (p_wdg) else $error("watchdog outputs not inverse");
a_stop: assert property (p_stop) else $error("no reset on stop entry");
a_stdby: assert property (p_stdby) else $error("no reset on standby entry");
a_quiet: assert property (p_quiet) else $error("reset while inhibited");
a_hold: assert property (p_hold) else $error("word request moved early");
a_last: assert property (p_last) else $error("request after last word");
a_load: assert property (p_load) else $error("load never finished");
endmodule // obd_properties

// ===== dv/obd_option_byte_decoder_tb.sv
// Self-checking bench for the option byte decoder
`timescale 1ns/1ps
module obd_option_byte_decoder_tb;
reg pclk, presetn, psel, penable, pwrite, standby_entry, stop_entry;
reg [7:0] paddr, b, r;
reg [31:0] pwdata, rd;
reg [127:0] words;
reg [1:0] delay, m;
reg er;
reg [64:0] e;
wire [31:0] prdata, info_rdata;
wire [255:0] page_protect;
wire [1:0] info_index;
wire pready, pslverr, info_req, info_valid, loading, watchdog_software_select;
wire hardware_watchdog_start, standby_reset_inhibit, stop_reset_inhibit;
wire low_power_reset, read_protect_active, irq;
integer num_errors, n_checks, seed, it, k, cyc = 0;
obd_option_byte_decoder i_obd_option_byte_decoder (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .info_req, .info_index,
	.info_rdata, .info_valid, .standby_entry, .stop_entry, .loading,
	.watchdog_software_select, .hardware_watchdog_start, .standby_reset_inhibit,
	.stop_reset_inhibit, .low_power_reset, .read_protect_active, .page_protect, .irq);
obd_info_model i_obd_info_model (.pclk, .presetn, .info_req, .info_index, .words,
	.delay, .info_rdata, .info_valid);
// Checked byte lanes plus load error flag
function [64:0] fx(input [127:0] w);
	integer j;
	reg [15:0] p;
	begin
		fx = 65'h0;
		for (j = 0; j < 8; j = j + 1) begin
			p = w[j*16 +: 16];
			if (p[7:0] == ~p[15:8] || p == 16'hffff)
				fx[j*8 +: 8] = p[7:0];
			else begin
				fx[j*8 +: 8] = 8'hff;
				fx[64] = 1'b1;
			end
		end
	end
endfunction
function [31:0] osr(input [64:0] v);
	osr = {6'h0, v[31:8], v[7:0] != 8'ha5, v[64]};
endfunction
function [255:0] pp(input [1:0] d, input [31:0] g);
	integer p;
	for (p = 0; p < 256; p = p + 1)
		pp[p] = d == 2'd2 ? (p < 62 ? !g[p/2] : !g[31]) : (p < 128 && !g[p/4]);
endfunction
task chk(input [255:0] g, input [255:0] x);
	begin
		n_checks = n_checks + 1;
		if (g !== x) begin
			num_errors = num_errors + 1;
			$display("unexpected at %0t: got %h exp %h", $time, g, x);
		end
	end
endtask
task apb(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
endtask
task load(input [1:0] d);
	begin
		apb(1'b1, 8'h08, {27'h0, 1'b1, 2'h0, d});
		for (k = 0; k < 10 && loading !== 1'b1; k = k + 1)
			@(negedge pclk);
		while (loading !== 1'b0)
			@(negedge pclk);
		repeat (3) @(posedge pclk);
	end
endtask
task report_and_stop;
	begin
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
endtask
initial begin
	pclk = 1'b0;
	forever #2 pclk = ~pclk;
end
// Ceiling far above the few hundred cycles the run needs
always @(posedge pclk) begin
	cyc = cyc + 1;
	if (cyc == 20000) begin
		num_errors = num_errors + 1;
		report_and_stop;
	end
end
initial begin
	seed = 32'h7190692b;
	{psel, penable, pwrite, standby_entry, stop_entry} = 5'h0;
	paddr = 8'h0;
	pwdata = 32'h0;
	words = {128{1'b1}};
	delay = 2'h0;
	presetn = 1'b0;
	num_errors = 0;
	n_checks = 0;
	repeat (10) @(posedge pclk);
	chk(page_protect, {256{1'b1}});
	presetn <= 1'b1;
	apb(1'b0, 8'h00, 32'h0);
	chk(rd, 32'h2);
	while (loading !== 1'b0)
		@(posedge pclk);
	chk(read_protect_active, 1'b1);
	for (it = 0; it < 9; it = it + 1) begin
		for (k = 0; k < 8; k = k + 1) begin
			b = $random(seed);
			r = $random(seed);
			if (k == 1) b[7:3] = 5'h1f;
			if (k == 0 && it % 2 == 1) b = 8'ha5;
			words[k*16 +: 16] = {~b, b};
			if (r[2:0] == 3'h0) words[k*16 +: 16] = 16'hffff;
			if (r[2:0] == 3'h1) words[k*16 + 8] = b[0];
		end
		delay <= $random(seed);
		m = $random(seed);
		apb(1'b1, 8'h10, {30'h0, m});
		load(it % 3);
		e = fx(words);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, osr(e));
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, e[63:32]);
		chk(page_protect, pp(it % 3, e[63:32]));
		chk(irq, |({e[64], 1'b1} & m));
		apb(1'b0, 8'h0c, 32'h0);
		chk(rd[1:0], {e[64], 1'b1});
		@(negedge pclk);
		chk(irq, 1'b0);
		chk({watchdog_software_select, read_protect_active}, {e[8], e[7:0] != 8'ha5});
		for (k = 0; k < 2; k = k + 1) begin
			@(posedge pclk);
			{standby_entry, stop_entry} <= k ? 2'b10 : 2'b01;
			@(posedge pclk);
			{standby_entry, stop_entry} <= 2'b00;
			@(negedge pclk);
			chk(low_power_reset, !e[9+k]);
		end
		$display("test %0d done", it);
	end
	apb(1'b0, 8'h20, 32'h0);
	chk({er, rd}, 33'h1_0000_0000);
	apb(1'b1, 8'h00, 32'hffff_ffff);
	apb(1'b0, 8'h00, 32'h0);
	chk(rd, osr(e));
	report_and_stop;
end
endmodule // obd_option_byte_decoder_tb
bind obd_option_byte_decoder obd_properties #(.ADDR_WIDTH(ADDR_WIDTH)) u_props (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .prdata, .info_req, .info_index,
	.info_valid, .standby_entry, .stop_entry, .loading, .watchdog_software_select,
	.hardware_watchdog_start, .standby_reset_inhibit, .stop_reset_inhibit,
	.low_power_reset, .read_protect_active);

// ===== rtl/obd_defines.vh
// Constants for the option byte decoder: offsets, fields, codes and reset values
`ifndef OBD_DEFINES_VH
`define OBD_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OBD_ADDR_OPT_STATUS 8'h00
`define OBD_ADDR_WRITE_GUARD 8'h04
`define OBD_ADDR_CONTROL 8'h08
`define OBD_ADDR_IRQ_STATUS 8'h0c
`define OBD_ADDR_IRQ_MASK 8'h10

// ----------------------------------------
// Option word layout (byte lanes)
// ----------------------------------------
`define OBD_LO_BYTE 7:0
`define OBD_LO_COMP 15:8
`define OBD_HI_BYTE 23:16
`define OBD_HI_COMP 31:24
`define OBD_WORD_USER 2'd0
`define OBD_WORD_DATA 2'd1
`define OBD_WORD_GUARD_LO 2'd2
`define OBD_WORD_GUARD_HI 2'd3

// ----------------------------------------
// User configuration byte
// ----------------------------------------
`define OBD_USER_WDG_BIT 0
`define OBD_USER_STOP_BIT 1
`define OBD_USER_STDBY_BIT 2
`define OBD_USER_USED 2:0
`define OBD_USER_UNUSED_VAL 5'h1f

// ----------------------------------------
// Option status register fields
// ----------------------------------------
`define OBD_OSR_ERR_BIT 0
`define OBD_OSR_RDP_BIT 1
`define OBD_OSR_USER 9:2
`define OBD_OSR_USER_LSB 2
`define OBD_OSR_USER_DATA_BYTE_ZERO 17:10
`define OBD_OSR_USER_DATA_BYTE_ONE 25:18
`define OBD_OSR_RESET 32'h0000_0002
`define OBD_WGR_RESET 32'h0000_0000

// ----------------------------------------
// Codes and misc fields
// ----------------------------------------
`define OBD_ERASED 8'hff
`define OBD_UNPROTECT_KEY 8'ha5
`define OBD_CTRL_DENSITY 1:0
`define OBD_CTRL_RELOAD_BIT 4
`define OBD_DENS_LOW 2'd0
`define OBD_DENS_MED 2'd1
`define OBD_DENS_HIGH 2'd2
`define OBD_IRQ_DONE_BIT 0
`define OBD_IRQ_ERR_BIT 1
`define OBD_HD_SPLIT_PAGE 62
`define OBD_HD_LAST_BIT 31

`endif

// ===== rtl/obd_option_byte_decoder.v
// Option byte loader and decoder with APB register access
`timescale 1ns/1ps
`include "obd_defines.vh"

// Operation
// - User byte from word 0 bits 23:16 appears in status bits 9:2.
// - Only user bits 16-18 matter; unused upper five bits read 0x1f.
// - Standby inhibit bit 0 resets on standby entry; 1 means no reset.
// - Stop inhibit bit 0 resets on stop entry; 1 means no reset.
// - Watchdog select 0 hardware-started watchdog, 1 software-started.
// - Flash readable only with read-protect byte equal to unprotect key.
// - Read protection state reported as one flag in status bit 1.
// - User data byte one to bits 25:18, byte zero to 17:10.
// - Four page guard bytes fill write guard register bytes 0 to 3.
// - Guard bit value 0 protects its page group, 1 leaves it open.
// - Low and medium density: one guard bit per four 1K pages.
// - Medium density: byte zero pages 0-31, byte one pages 32-63, onward.
// - High density: one guard bit per two 2K pages; byte zero pages 0-15.
// - High density pages 16-47 follow in two-page groups, bytes one, two.
// - High density byte three bits 0-6 guard pages 48-61.
// - High density byte three bit 7 guards pages 62-255 as one unit.
// - Every system reset reloads both registers from the information block.
// - Byte mismatching its complement raises load error and reads 0xff.
// - No complement check when byte and complement are both 0xff.
module obd_option_byte_decoder #(
	parameter NUM_PAGES = 256,
	parameter ADDR_WIDTH = 8
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_WIDTH-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output reg info_req,
	output reg [1:0] info_index,
	input wire [31:0] info_rdata,
	input wire info_valid,
	input wire standby_entry,
	input wire stop_entry,
	output reg loading,
	output wire watchdog_software_select,
	output wire hardware_watchdog_start,
	output wire standby_reset_inhibit,
	output wire stop_reset_inhibit,
	output reg low_power_reset,
	output wire read_protect_active,
	output reg [NUM_PAGES-1:0] page_protect,
	output wire irq
);

	// ----------------------------------------
	// State and registers
	// ----------------------------------------
	localparam ST_IDLE = 2'd0;
	localparam ST_REQ = 2'd1;
	localparam ST_DONE = 2'd2;

	reg [1:0] state;
	reg [31:0] option_status_register;
	reg [31:0] write_guard_register;
	reg [31:0] shadow_status;
	reg [31:0] shadow_guard;
	reg [1:0] density;
	reg [1:0] irq_status;
	reg [1:0] irq_mask;
	reg done_pulse;
	reg [1:0] next_state;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire apb_access = psel & penable;
	wire apb_write = apb_access & pwrite;
	wire apb_read = apb_access & ~pwrite;
	wire sel_opt_status = (paddr == `OBD_ADDR_OPT_STATUS);
	wire sel_write_guard = (paddr == `OBD_ADDR_WRITE_GUARD);
	wire sel_control = (paddr == `OBD_ADDR_CONTROL);
	wire sel_irq_status = (paddr == `OBD_ADDR_IRQ_STATUS);
	wire sel_irq_mask = (paddr == `OBD_ADDR_IRQ_MASK);
	wire addr_hit = sel_opt_status | sel_write_guard | sel_control | sel_irq_status |
		sel_irq_mask;
	wire control_write = apb_write & sel_control;
	wire mask_write = apb_write & sel_irq_mask;
	wire reload_cmd = control_write & pwdata[`OBD_CTRL_RELOAD_BIT];

	// Zero wait states: every access ends in its first access cycle
	assign pready = 1'b1;
	// Unmapped offsets answer with an error and change nothing
	assign pslverr = apb_access & ~addr_hit;

	// ----------------------------------------
	// Byte check against complement
	// ----------------------------------------
	// Returns {error, checked byte}
	function [8:0] check_byte;
		input [7:0] value;
		input [7:0] comp;
		begin
			if (value == `OBD_ERASED && comp == `OBD_ERASED)
				check_byte = {1'b0, `OBD_ERASED};
			else if (comp != ~value)
				check_byte = {1'b1, `OBD_ERASED};
			else
				check_byte = {1'b0, value};
		end
	endfunction

	wire [8:0] chk_lo = check_byte(info_rdata[`OBD_LO_BYTE], info_rdata[`OBD_LO_COMP]);
	wire [8:0] chk_hi = check_byte(info_rdata[`OBD_HI_BYTE], info_rdata[`OBD_HI_COMP]);
	wire word_err = chk_lo[8] | chk_hi[8];

	// ----------------------------------------
	// Loader sequence
	// ----------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: next_state = ST_REQ;
			ST_REQ: begin
				if (info_valid && info_index == `OBD_WORD_GUARD_HI)
					next_state = ST_DONE;
			end
			ST_DONE: begin
				if (reload_cmd)
					next_state = ST_REQ;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// Loader events
	// ----------------------------------------
	wire word_take = (state == ST_REQ) & info_valid;
	wire last_take = word_take & (info_index == `OBD_WORD_GUARD_HI);
	// Reset lands in ST_IDLE, so every reset starts a fresh load
	wire start_load = (state == ST_IDLE) | ((state == ST_DONE) & reload_cmd);
	wire publish = (state == ST_DONE) & loading;
	wire state_illegal = (state != ST_IDLE) & (state != ST_REQ) & (state != ST_DONE);

	// Fields of the first word, already checked against their complements
	wire [7:0] user_field = {`OBD_USER_UNUSED_VAL, chk_hi[`OBD_USER_USED]};
	wire rdp_closed = (chk_lo[7:0] != `OBD_UNPROTECT_KEY);

	// ----------------------------------------
	// Word requests towards the information block
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			info_req <= 1'b0;
			info_index <= `OBD_WORD_USER;
			loading <= 1'b1;
			done_pulse <= 1'b0;
		end else begin
			state <= next_state;
			done_pulse <= publish;
			if (start_load) begin
				info_req <= 1'b1;
				info_index <= `OBD_WORD_USER;
			end else if (last_take) begin
				info_req <= 1'b0;
			end else if (word_take) begin
				info_index <= info_index + 2'd1;
			end else if (state_illegal) begin
				info_req <= 1'b0;
			end
			// A reload in the publishing cycle keeps the loader busy
			if (start_load)
				loading <= 1'b1;
			else if (publish)
				loading <= 1'b0;
		end
	end

	// ----------------------------------------
	// Shadow copies filled word by word
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shadow_status <= `OBD_OSR_RESET;
		end else if (start_load) begin
			shadow_status <= `OBD_OSR_RESET;
		end else if (word_take) begin
			case (info_index)
				`OBD_WORD_USER: begin
					shadow_status[`OBD_OSR_USER] <= user_field;
					shadow_status[`OBD_OSR_RDP_BIT] <= rdp_closed;
				end
				`OBD_WORD_DATA: begin
					shadow_status[`OBD_OSR_USER_DATA_BYTE_ONE] <= chk_hi[7:0];
					shadow_status[`OBD_OSR_USER_DATA_BYTE_ZERO] <= chk_lo[7:0];
				end
				default: begin
					shadow_status <= shadow_status;
				end
			endcase
			if (word_err)
				shadow_status[`OBD_OSR_ERR_BIT] <= 1'b1;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shadow_guard <= `OBD_WGR_RESET;
		end else if (word_take) begin
			case (info_index)
				`OBD_WORD_GUARD_LO: begin
					shadow_guard[15:0] <= {chk_hi[7:0], chk_lo[7:0]};
				end
				`OBD_WORD_GUARD_HI: begin
					shadow_guard[31:16] <= {chk_hi[7:0], chk_lo[7:0]};
				end
				default: begin
					shadow_guard <= shadow_guard;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Publishing
	// ----------------------------------------
	// All four words appear at once, never a half-loaded set
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			option_status_register <= `OBD_OSR_RESET;
			write_guard_register <= `OBD_WGR_RESET;
		end else if (publish) begin
			option_status_register <= shadow_status;
			write_guard_register <= shadow_guard;
		end
	end

	// ----------------------------------------
	// Decoded configuration
	// ----------------------------------------
	assign watchdog_software_select =
		option_status_register[`OBD_OSR_USER_LSB + `OBD_USER_WDG_BIT];
	assign hardware_watchdog_start = ~watchdog_software_select;
	assign stop_reset_inhibit =
		option_status_register[`OBD_OSR_USER_LSB + `OBD_USER_STOP_BIT];
	assign standby_reset_inhibit =
		option_status_register[`OBD_OSR_USER_LSB + `OBD_USER_STDBY_BIT];
	assign read_protect_active = option_status_register[`OBD_OSR_RDP_BIT];

	wire standby_reset_req = standby_entry & ~standby_reset_inhibit;
	wire stop_reset_req = stop_entry & ~stop_reset_inhibit;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			low_power_reset <= 1'b0;
		else
			low_power_reset <= standby_reset_req | stop_reset_req;
	end

	// ----------------------------------------
	// Per-page protection
	// ----------------------------------------
	// Page index is in units of the density's own page size
	genvar p;
	generate
		for (p = 0; p < NUM_PAGES; p = p + 1) begin : g_page
			localparam integer LM_BIT = p / 4;
			localparam integer HD_BIT = (p < `OBD_HD_SPLIT_PAGE) ? p / 2 : `OBD_HD_LAST_BIT;
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					page_protect[p] <= 1'b1;
				end else if (density == `OBD_DENS_HIGH) begin
					page_protect[p] <= ~write_guard_register[HD_BIT];
				end else if (LM_BIT < 32) begin
					page_protect[p] <= ~write_guard_register[LM_BIT % 32];
				end else begin
					page_protect[p] <= 1'b0;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Control, interrupt status and mask
	// ----------------------------------------
	wire irq_status_read = apb_read & sel_irq_status;
	wire load_err_event = done_pulse & option_status_register[`OBD_OSR_ERR_BIT];
	wire [1:0] irq_events = {load_err_event, done_pulse};
	wire [1:0] irq_kept = irq_status_read ? 2'b00 : irq_status;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			density <= `OBD_DENS_MED;
		else if (control_write)
			density <= pwdata[`OBD_CTRL_DENSITY];
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_mask <= 2'b00;
		else if (mask_write)
			irq_mask <= pwdata[1:0];
	end

	// New event wins over the clearing read, so no event is lost
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_status <= 2'b00;
		else
			irq_status <= irq_kept | irq_events;
	end

	assign irq = |(irq_status & irq_mask);

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always @* begin
		prdata = 32'h0000_0000;
		if (apb_read) begin
			case (paddr)
				`OBD_ADDR_OPT_STATUS: begin
					prdata = option_status_register;
				end
				`OBD_ADDR_WRITE_GUARD: begin
					prdata = write_guard_register;
				end
				`OBD_ADDR_CONTROL: begin
					// Reload bit is a strobe and reads back as zero
					prdata = {30'h0000_0000, density};
				end
				`OBD_ADDR_IRQ_STATUS: begin
					prdata = {30'h0000_0000, irq_status};
				end
				`OBD_ADDR_IRQ_MASK: begin
					prdata = {30'h0000_0000, irq_mask};
				end
				default: begin
					prdata = 32'h0000_0000;
				end
			endcase
		end
	end

endmodule // obd_option_byte_decoder
